// [include/crt_pkg.sv]
// package: handshake codes, cycle types and widths for register moves
package crt_pkg;
   localparam int CRT_DATA_W = 32;
   localparam int CRT_ADDR_W = 32;
   // handshake codes shared by both ends
   localparam logic [1:0] CRT_HS_ABSENT = 2'h0;
   localparam logic [1:0] CRT_HS_STALL = 2'h1;
   localparam logic [1:0] CRT_HS_PROCEED = 2'h2;
   localparam logic [1:0] CRT_HS_FINAL = 2'h3;
   // move kinds
   localparam logic [1:0] CRT_OP_TO_CORE = 2'h0;
   localparam logic [1:0] CRT_OP_TO_COPRO = 2'h1;
   localparam logic [1:0] CRT_OP_PAIR_TO_CORE = 2'h2;
   localparam logic [1:0] CRT_OP_PAIR_TO_COPRO = 2'h3;
   // cycle types as {request_n, seq}
   localparam logic [1:0] CRT_CYC_NSEQ = 2'h0;
   localparam logic [1:0] CRT_CYC_SEQ = 2'h1;
   localparam logic [1:0] CRT_CYC_IDLE = 2'h2;
   localparam logic [1:0] CRT_CYC_COPRO = 2'h3;
   // fetch offset from pc: three instruction steps of four bytes
   localparam logic [31:0] CRT_PC_AHEAD = 32'h0000000c;
endpackage : crt_pkg

// [include/crt_if.sv]
// interface: core to coprocessor register move link
`timescale 1ns/1ns
`default_nettype none
interface crt_if;
   import crt_pkg::*;
   logic [1:0] decode_handshake;
   logic [1:0] execute_handshake;
   logic fetch_request_n;
   logic fetch_seq_flag;
   logic mem_request_n;
   logic mem_seq_flag;
   logic [CRT_ADDR_W-1:0] fetch_address;
   logic [CRT_ADDR_W-1:0] load_store_address;
   logic [CRT_DATA_W-1:0] read_data;
   logic [CRT_DATA_W-1:0] write_data;
   logic cond_pass;
   logic late_abort_flag;
   logic [1:0] op_kind;
   logic op_valid;
   modport core (
      input decode_handshake, execute_handshake, read_data,
      output fetch_request_n, fetch_seq_flag, mem_request_n, mem_seq_flag,
      output fetch_address, load_store_address, write_data, cond_pass,
      output late_abort_flag, op_kind, op_valid
   );
   modport copro (
      output decode_handshake, execute_handshake, read_data,
      input fetch_request_n, fetch_seq_flag, mem_request_n, mem_seq_flag,
      input fetch_address, load_store_address, write_data, cond_pass,
      input late_abort_flag, op_kind, op_valid
   );
endinterface : crt_if
`default_nettype wire

// [rtl/crt_core_end.sv]
// core end: sequences register moves to and from the coprocessor
// How it works
// - single read copies one coprocessor word in
// - read word on read bus, no address
// - ready read: final, one sequential copro cycle
// - stall until final, transfer next cycle
// - single write sends one core register
// - write word on write bus, no address
// - copro cycle after final, data next phase
// - fetch held at pc+3i, idle until last
// - pair read moves two words in order
// - pair ready: proceed, final, two copro cycles
// - stall, proceed n, final n+1, data n+2
// - pair write: first then second word
// - pass held 1, late abort held 0
// - interrupt may abandon a stalled move
// - moves only in 32-bit instruction state
// - coprocessor signals proceed (pair) or final (single) when ready
// - final comes one cycle before first word
// - handshakes absent when nobody handles it
`timescale 1ns/1ns
`default_nettype none
module crt_core_end
   import crt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // user request side
   input wire logic start,
   input wire logic [1:0] op,
   input wire logic thumb_state,
   input wire logic irq_take,
   input wire logic [CRT_ADDR_W-1:0] pc,
   input wire logic [CRT_DATA_W-1:0] first_source_reg,
   input wire logic [CRT_DATA_W-1:0] second_source_reg,
   output logic busy,
   output logic done,
   output logic abandoned,
   output logic refused,
   output logic absent,
   output logic dest_we,
   output logic dest_sel,
   output logic [CRT_DATA_W-1:0] dest_data,
   // link
   crt_if.core lnk
);
   typedef enum {CRT_IDLE, CRT_DEC, CRT_EXE, CRT_XFER1, CRT_XFER2, CRT_RD2}
      crt_state_e;
   crt_state_e state_reg;
   logic [1:0] op_reg;
   logic [CRT_DATA_W-1:0] src2_reg;
   logic pair;
   logic to_core;
   assign pair = op_reg[1];
   assign to_core = (op_reg == CRT_OP_TO_CORE) ||
                    (op_reg == CRT_OP_PAIR_TO_CORE);

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= CRT_IDLE;
         op_reg <= CRT_OP_TO_CORE;
         src2_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         abandoned <= 1'b0;
         refused <= 1'b0;
         absent <= 1'b0;
         lnk.op_valid <= 1'b0;
         lnk.op_kind <= CRT_OP_TO_CORE;
      end else if (clk_en) begin
         done <= 1'b0;
         abandoned <= 1'b0;
         refused <= 1'b0;
         absent <= 1'b0;
         case (state_reg)
            CRT_IDLE: begin
               if (start && thumb_state) begin
                  refused <= 1'b1;
               end else if (start) begin
                  op_reg <= op;
                  src2_reg <= second_source_reg;
                  lnk.op_kind <= op;
                  lnk.op_valid <= 1'b1;
                  busy <= 1'b1;
                  state_reg <= CRT_DEC;
               end
            end
            CRT_DEC: begin
               lnk.op_valid <= 1'b0;
               // registered answer: code stands one cycle after the request
               if (!lnk.op_valid) begin
                  case (lnk.decode_handshake)
                     CRT_HS_FINAL: state_reg <= CRT_XFER1;
                     CRT_HS_PROCEED: state_reg <= CRT_EXE;
                     CRT_HS_STALL: state_reg <= CRT_EXE;
                     default: begin
                        absent <= 1'b1;
                        busy <= 1'b0;
                        state_reg <= CRT_IDLE;
                     end
                  endcase
               end
            end
            CRT_EXE: begin
               if (lnk.execute_handshake == CRT_HS_FINAL) begin
                  state_reg <= pair ? CRT_XFER2 : CRT_XFER1;
               end else if (lnk.execute_handshake == CRT_HS_ABSENT) begin
                  absent <= 1'b1;
                  busy <= 1'b0;
                  state_reg <= CRT_IDLE;
               end else if (irq_take &&
                            lnk.execute_handshake == CRT_HS_STALL) begin
                  abandoned <= 1'b1;
                  busy <= 1'b0;
                  state_reg <= CRT_IDLE;
               end
            end
            CRT_XFER2: state_reg <= CRT_XFER1;
            CRT_XFER1: begin
               if (to_core) begin
                  state_reg <= CRT_RD2;
               end else begin
                  done <= 1'b1;
                  busy <= 1'b0;
                  state_reg <= CRT_IDLE;
               end
            end
            CRT_RD2: begin
               done <= 1'b1;
               busy <= 1'b0;
               state_reg <= CRT_IDLE;
            end
            default: state_reg <= CRT_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // fetch and data cycle outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         lnk.fetch_request_n <= CRT_CYC_IDLE[1];
         lnk.fetch_seq_flag <= CRT_CYC_IDLE[0];
         lnk.mem_request_n <= CRT_CYC_IDLE[1];
         lnk.mem_seq_flag <= CRT_CYC_IDLE[0];
         lnk.fetch_address <= '0;
         lnk.load_store_address <= '0;
         lnk.cond_pass <= 1'b0;
         lnk.late_abort_flag <= 1'b0;
      end else if (clk_en) begin
         lnk.load_store_address <= '0;
         lnk.late_abort_flag <= 1'b0;
         lnk.cond_pass <= (state_reg != CRT_IDLE);
         if (state_reg == CRT_IDLE && start && !thumb_state) begin
            lnk.fetch_address <= pc + CRT_PC_AHEAD;
         end
         {lnk.fetch_request_n, lnk.fetch_seq_flag} <= CRT_CYC_IDLE;
         {lnk.mem_request_n, lnk.mem_seq_flag} <= CRT_CYC_IDLE;
         if ((state_reg == CRT_DEC &&
              lnk.decode_handshake == CRT_HS_FINAL) ||
             (state_reg == CRT_EXE && !pair &&
              lnk.execute_handshake == CRT_HS_FINAL) ||
             state_reg == CRT_XFER2) begin
            {lnk.fetch_request_n, lnk.fetch_seq_flag} <= CRT_CYC_SEQ;
            {lnk.mem_request_n, lnk.mem_seq_flag} <= CRT_CYC_COPRO;
         end else if (state_reg == CRT_EXE && pair &&
                      lnk.execute_handshake == CRT_HS_FINAL) begin
            {lnk.mem_request_n, lnk.mem_seq_flag} <= CRT_CYC_COPRO;
         end
      end
   end

   // ------------------------------------------------------------
   // data words: writes one phase after each copro cycle
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         lnk.write_data <= '0;
      end else if (clk_en) begin
         if (state_reg == CRT_XFER2 ||
             (state_reg == CRT_XFER1 && !pair)) begin
            lnk.write_data <= first_source_reg;
         end else if (state_reg == CRT_XFER1) begin
            lnk.write_data <= src2_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dest_we <= 1'b0;
         dest_sel <= 1'b0;
         dest_data <= '0;
      end else if (clk_en) begin
         dest_we <= 1'b0;
         if (to_core && (state_reg == CRT_XFER1 || state_reg == CRT_RD2)
             && (pair || state_reg == CRT_RD2)) begin
            dest_we <= 1'b1;
            dest_sel <= pair && state_reg == CRT_RD2;
            dest_data <= lnk.read_data;
         end
      end
   end
endmodule : crt_core_end
`default_nettype wire

// [rtl/crt_copro_end.sv]
// coprocessor end: answers handshakes and moves register words
`timescale 1ns/1ns
`default_nettype none
module crt_copro_end
   import crt_pkg::*;
#(
   parameter int STALL_W = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // user side
   input wire logic present,
   input wire logic [STALL_W-1:0] stall_cycles,
   input wire logic [CRT_DATA_W-1:0] word_a,
   input wire logic [CRT_DATA_W-1:0] word_b,
   output logic got_we,
   output logic got_sel,
   output logic [CRT_DATA_W-1:0] got_data,
   // link
   crt_if.copro lnk
);
   typedef enum {CPE_IDLE, CPE_WAIT, CPE_PROC, CPE_DATA}
      cpe_state_e;
   cpe_state_e state_reg;
   logic [STALL_W-1:0] cnt_reg;
   logic [1:0] op_reg;
   logic [1:0] words_reg;
   logic sel_reg;

   // ------------------------------------------------------------
   // handshake sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= CPE_IDLE;
         cnt_reg <= '0;
         op_reg <= CRT_OP_TO_CORE;
         lnk.decode_handshake <= CRT_HS_ABSENT;
         lnk.execute_handshake <= CRT_HS_ABSENT;
      end else if (clk_en) begin
         lnk.decode_handshake <= CRT_HS_ABSENT;
         lnk.execute_handshake <= CRT_HS_ABSENT;
         case (state_reg)
            CPE_IDLE: begin
               if (lnk.op_valid && present) begin
                  op_reg <= lnk.op_kind;
                  cnt_reg <= stall_cycles;
                  if (stall_cycles != '0) begin
                     lnk.decode_handshake <= CRT_HS_STALL;
                     state_reg <= CPE_WAIT;
                  end else if (lnk.op_kind[1]) begin
                     lnk.decode_handshake <= CRT_HS_PROCEED;
                     state_reg <= CPE_PROC;
                  end else begin
                     lnk.decode_handshake <= CRT_HS_FINAL;
                     state_reg <= CPE_DATA;
                  end
               end
            end
            CPE_WAIT: begin
               if (cnt_reg > 1) begin
                  cnt_reg <= cnt_reg - 1'b1;
                  lnk.execute_handshake <= CRT_HS_STALL;
               end else if (op_reg[1]) begin
                  lnk.execute_handshake <= CRT_HS_PROCEED;
                  state_reg <= CPE_PROC;
               end else begin
                  lnk.execute_handshake <= CRT_HS_FINAL;
                  state_reg <= CPE_DATA;
               end
            end
            CPE_PROC: begin
               lnk.execute_handshake <= CRT_HS_FINAL;
               state_reg <= CPE_DATA;
            end
            CPE_DATA: begin
               if (!lnk.mem_request_n == 1'b0 && words_reg == 2'h0 &&
                   lnk.mem_seq_flag == 1'b0) begin
                  state_reg <= CPE_IDLE;
               end
            end
            default: state_reg <= CPE_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // data words: one per copro cycle, in order
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         words_reg <= 2'h0;
         sel_reg <= 1'b0;
         got_we <= 1'b0;
         got_sel <= 1'b0;
         got_data <= '0;
         lnk.read_data <= '0;
      end else if (clk_en) begin
         got_we <= 1'b0;
         if (state_reg == CPE_IDLE) begin
            sel_reg <= 1'b0;
            words_reg <= 2'h0;
         end
         if ({lnk.mem_request_n, lnk.mem_seq_flag} == CRT_CYC_COPRO) begin
            words_reg <= words_reg + 2'h1;
            sel_reg <= 1'b1;
            lnk.read_data <= sel_reg ? word_b : word_a;
         end
         if (words_reg != 2'h0 && !op_reg[0] == 1'b0) begin
            got_we <= 1'b1;
            got_sel <= words_reg == 2'h2;
            got_data <= lnk.write_data;
            words_reg <= ({lnk.mem_request_n, lnk.mem_seq_flag} ==
                          CRT_CYC_COPRO) ? words_reg + 2'h1 : 2'h0;
         end else if (words_reg != 2'h0 &&
                      {lnk.mem_request_n, lnk.mem_seq_flag} !=
                      CRT_CYC_COPRO) begin
            words_reg <= 2'h0;
         end
      end
   end
endmodule : crt_copro_end
`default_nettype wire

// [testbench/crt_link_asserts.sv]
// checker: timing relations on the core to coprocessor link
`timescale 1ns/1ns
`default_nettype none
module crt_link_asserts
   import crt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // handshakes
   input wire logic [1:0] decode_handshake,
   input wire logic [1:0] execute_handshake,
   // cycle types
   input wire logic fetch_request_n,
   input wire logic fetch_seq_flag,
   input wire logic mem_request_n,
   input wire logic mem_seq_flag,
   // addresses and flags
   input wire logic [CRT_ADDR_W-1:0] fetch_address,
   input wire logic [CRT_ADDR_W-1:0] load_store_address,
   input wire logic cond_pass,
   input wire logic late_abort_flag
);
   logic [1:0] fcyc;
   logic [1:0] mcyc;
   assign fcyc = {fetch_request_n, fetch_seq_flag};
   assign mcyc = {mem_request_n, mem_seq_flag};
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_pair_tail;
      mcyc == CRT_CYC_COPRO && fcyc == CRT_CYC_IDLE
      ##1 mcyc == CRT_CYC_COPRO && fcyc == CRT_CYC_SEQ;
   endsequence
   property p_no_data_addr;
      load_store_address == 32'h0;
   endproperty
   property p_no_late_abort;
      late_abort_flag == 1'b0;
   endproperty
   property p_pass_in_copro;
      mcyc == CRT_CYC_COPRO |-> cond_pass;
   endproperty
   property p_fetch_held;
      cond_pass && $past(cond_pass) |-> $stable(fetch_address);
   endproperty
   property p_stall_idle;
      execute_handshake == CRT_HS_STALL
      |-> mcyc == CRT_CYC_IDLE && fcyc == CRT_CYC_IDLE;
   endproperty
   property p_seq_last;
      fcyc == CRT_CYC_SEQ |-> mcyc == CRT_CYC_COPRO;
   endproperty
   property p_no_extra_copro;
      fcyc == CRT_CYC_SEQ |=> mcyc != CRT_CYC_COPRO;
   endproperty
   property p_copro_after_final;
      $rose(mcyc == CRT_CYC_COPRO) |-> $past(decode_handshake) == CRT_HS_FINAL
      || $past(execute_handshake) == CRT_HS_FINAL
      || execute_handshake == CRT_HS_FINAL;
   endproperty
   property p_pair_tail;
      mcyc == CRT_CYC_COPRO && fcyc == CRT_CYC_IDLE |-> s_pair_tail;
   endproperty
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_no_data_addr: assert property (p_no_data_addr)
      else $error("data address driven during a move");
   a_no_late_abort: assert property (p_no_late_abort)
      else $error("late abort flag raised");
   a_pass_in_copro: assert property (p_pass_in_copro)
      else $error("condition pass low in a copro cycle");
   a_fetch_held: assert property (p_fetch_held)
      else $error("fetch address moved during a move");
   a_stall_idle: assert property (p_stall_idle)
      else $error("cycles not idle while stalled");
   a_seq_last: assert property (p_seq_last)
      else $error("sequential fetch outside the transfer cycle");
   a_no_extra_copro: assert property (p_no_extra_copro)
      else $error("copro cycle after the last transfer");
   a_copro_after_final: assert property (p_copro_after_final)
      else $error("copro cycle without a final code");
   a_pair_tail: assert property (p_pair_tail)
      else $error("pair transfer cycles out of order");
endmodule : crt_link_asserts
`default_nettype wire

// [testbench/tb_coproc_register_transfer.sv]
// testbench: both ends joined, register moves checked end to end
`timescale 1ns/1ns
`default_nettype none
module tb_coproc_register_transfer;
   import crt_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0;
   logic thumb_state = 1'b0;
   logic irq_take = 1'b0;
   logic present = 1'b1;
   logic [1:0] op = 2'h0;
   logic [3:0] stall_cycles = 4'h0;
   logic [31:0] pc = 32'h0, src_a = 32'h0, src_b = 32'h0;
   logic [31:0] word_a = 32'h0, word_b = 32'h0, dest_data, got_data;
   logic busy, done, abandoned, refused, absent;
   logic dest_we, dest_sel, got_we, got_sel;
   logic [32:0] exp_core[$], exp_copro[$], ec, ep;
   int n_errors = 0, total_checks = 0, seed = 70, lat, lat0[4];
   crt_if lnk();
   always #2 clk = ~clk;
   // ----------------------------------------
   // both ends and the checker
   // ----------------------------------------
   crt_core_end crt_core_end_i (.clk(clk), .reset(reset), .clk_en(1'b1),
      .start(start), .op(op), .thumb_state(thumb_state),
      .irq_take(irq_take), .pc(pc), .first_source_reg(src_a),
      .second_source_reg(src_b), .busy(busy), .done(done),
      .abandoned(abandoned), .refused(refused), .absent(absent),
      .dest_we(dest_we), .dest_sel(dest_sel), .dest_data(dest_data),
      .lnk(lnk));
   crt_copro_end crt_copro_end_i (.clk(clk), .reset(reset), .clk_en(1'b1),
      .present(present), .stall_cycles(stall_cycles), .word_a(word_a),
      .word_b(word_b), .got_we(got_we), .got_sel(got_sel),
      .got_data(got_data), .lnk(lnk));
   crt_link_asserts crt_link_asserts_i (.clk(clk), .reset(reset),
      .decode_handshake(lnk.decode_handshake),
      .execute_handshake(lnk.execute_handshake),
      .fetch_request_n(lnk.fetch_request_n),
      .fetch_seq_flag(lnk.fetch_seq_flag),
      .mem_request_n(lnk.mem_request_n), .mem_seq_flag(lnk.mem_seq_flag),
      .fetch_address(lnk.fetch_address),
      .load_store_address(lnk.load_store_address),
      .cond_pass(lnk.cond_pass), .late_abort_flag(lnk.late_abort_flag));
   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task chk(input string nm, input logic [32:0] ex, input logic [32:0] sn);
      total_checks++;
      if (ex !== sn) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, ex, sn);
      end
   endtask : chk
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      if (!reset && dest_we) begin
         ec = exp_core.size() ? exp_core.pop_front() : 'x;
         chk("core word", ec, {dest_sel, dest_data});
      end
   end
   always @(posedge clk) begin
      if (!reset && got_we) begin
         ep = exp_copro.size() ? exp_copro.pop_front() : 'x;
         chk("copro word", ep, {got_sel, got_data});
      end
   end
   // ----------------------------------------
   // driver: one move, outcome 0 done 1 abandoned 2 refused 3 absent
   // ----------------------------------------
   task run(input logic [1:0] o, input int st, input logic th, ir, pr,
            input int want);
      int k;
      logic [31:0] a, b, c, d;
      a = $random(seed);
      b = $random(seed);
      c = $random(seed);
      d = $random(seed);
      op <= o;
      stall_cycles <= st[3:0];
      thumb_state <= th;
      irq_take <= ir;
      present <= pr;
      word_a <= a;
      word_b <= b;
      src_a <= c;
      src_b <= d;
      pc <= $random(seed);
      if (want == 0 && o[0]) exp_copro.push_back({1'b0, c});
      if (want == 0 && o == 2'h3) exp_copro.push_back({1'b1, d});
      if (want == 0 && !o[0]) exp_core.push_back({1'b0, a});
      if (want == 0 && o == 2'h2) exp_core.push_back({1'b1, b});
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      k = 0;
      while (!(done || abandoned || refused || absent) && k < 300) begin
         @(posedge clk);
         k++;
      end
      chk("outcome", want, done ? 0 : abandoned ? 1 : refused ? 2 : 3);
      chk("busy after move", 33'h0, {32'h0, busy});
      lat = k;
   endtask : run
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      int st;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int o = 0; o < 4; o++) begin
         run(o[1:0], 0, 1'b0, 1'b0, 1'b1, 0);
         lat0[o] = lat;
      end
      chk("pair read extra", 33'h2, lat0[2] - lat0[0]);
      chk("pair write extra", 33'h2, lat0[3] - lat0[1]);
      $display("test ready moves done");
      for (int o = 0; o < 4; o++) begin
         st = 1 + ($random(seed) & 7);
         run(o[1:0], st, 1'b0, 1'b0, 1'b1, 0);
         chk("stall latency", st, lat - lat0[o]);
      end
      $display("test stalled moves done");
      run(2'h0, 0, 1'b1, 1'b0, 1'b1, 2);
      $display("test compressed state done");
      run(2'h1, 0, 1'b0, 1'b0, 1'b0, 3);
      $display("test absent coprocessor done");
      run(2'h2, 8, 1'b0, 1'b1, 1'b1, 1);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      $display("test abandon done");
      repeat (8) begin
         st = $random(seed);
         run(st[1:0], st[4:3], 1'b0, 1'b0, 1'b1, 0);
      end
      repeat (4) @(posedge clk);
      chk("words left", 33'h0, exp_core.size() + exp_copro.size());
      $display("test random moves done");
      report_and_stop;
   end
   // watchdog: all moves together need well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop;
   end
endmodule : tb_coproc_register_transfer
`default_nettype wire
